// File: hw/metering_cfg_pkg.sv
// Constants shared by the metering configuration register logic
package metering_cfg_pkg;
   // Register address and width
   localparam logic [15:0] CFG_ADDR = 16'hE618;
   localparam int CFG_WIDTH = 16;
   // Field positions inside the configuration word
   localparam int SETTLE_BIT = 5;
   localparam int FAST_PORT_BIT = 6;
   localparam int SOFT_RESET_BIT = 7;
   localparam int VOLT_A_LSB = 8;
   localparam int VOLT_B_LSB = 10;
   localparam int VOLT_C_LSB = 12;
   localparam int NEUTRAL_SRC_BIT = 14;
   // Values after reset
   localparam logic CFG_BIT_RESET = 1'h0;
   localparam logic [1:0] VOLT_FIELD_RESET = 2'h0;
   localparam logic [15:0] READ_IDLE = 16'h0000;
   // Phase codes on the voltage selection outputs
   localparam logic [1:0] PHASE_A = 2'h0;
   localparam logic [1:0] PHASE_B = 2'h1;
   localparam logic [1:0] PHASE_C = 2'h2;
   localparam logic [1:0] PHASE_RSVD = 2'h3;
   // Timing
   localparam int unsigned CLK_KHZ = 40000;
   localparam int unsigned SETTLE_SHORT_MS = 650;
   localparam int unsigned SETTLE_LONG_MS = 1300;
   localparam int unsigned SETTLE_SHORT_CYC = SETTLE_SHORT_MS * CLK_KHZ;
   localparam int unsigned SETTLE_LONG_CYC = SETTLE_LONG_MS * CLK_KHZ;
   localparam int unsigned SOFT_RESET_CYC = 16;
   // Soft reset sequencer states
   typedef enum logic {SR_IDLE, SR_BUSY} soft_reset_state_t;
endpackage

// File: hw/phase_voltage_map.sv
// Maps a two-bit voltage pairing field to the phase code it selects
`timescale 1ns/100ps
`default_nettype none
module phase_voltage_map
   import metering_cfg_pkg::*;
#(
   parameter logic [1:0] BASE_PHASE = PHASE_A
) (
   input wire logic [1:0] field_i,
   output logic [1:0] phase_o
);
   // Rotate from the own phase; the unused code falls back to the own phase
   always_comb begin
      phase_o = BASE_PHASE;
      case (field_i)
         2'h0: phase_o = BASE_PHASE;
         2'h1: phase_o = (BASE_PHASE == PHASE_C) ? PHASE_A : 2'(BASE_PHASE + 2'h1);
         2'h2: phase_o = (BASE_PHASE == PHASE_A) ? PHASE_C : 2'(BASE_PHASE - 2'h1);
         default: phase_o = BASE_PHASE;
      endcase
   end
endmodule
`default_nettype wire

// File: hw/metering_config_upper_fields.sv
// Upper fields of the general configuration register and their effects
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
module metering_config_upper_fields
   import metering_cfg_pkg::*;
#(
   parameter int unsigned SETTLE_SHORT_CYCLES = SETTLE_SHORT_CYC,
   parameter int unsigned SETTLE_LONG_CYCLES = SETTLE_LONG_CYC,
   parameter int unsigned SOFT_RESET_CYCLES = SOFT_RESET_CYC,
   parameter int RMS_WIDTH = 24
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [15:0] addr_i,
   input wire logic [CFG_WIDTH-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [CFG_WIDTH-1:0] rdata_o,
   output logic power_filter_settle_select_o,
   output logic [31:0] filter_settle_cycles_o,
   output logic fast_data_port_enable_o,
   input wire logic third_pulse_output_i,
   input wire logic fast_port_clock_i,
   output logic shared_pin_o,
   output logic soft_reset_o,
   output logic [1:0] voltage_for_current_a_o,
   output logic [1:0] voltage_for_current_b_o,
   output logic [1:0] voltage_for_current_c_o,
   output logic neutral_rms_source_select_o,
   input wire logic [RMS_WIDTH-1:0] neutral_current_rms_i,
   input wire logic [RMS_WIDTH-1:0] phase_current_sum_i,
   output logic [RMS_WIDTH-1:0] neutral_rms_o
);
   soft_reset_state_t state;
   logic [31:0] reset_count;
   logic settle_sel;
   logic fast_port_en;
   logic neutral_sel;
   logic [1:0] volt_field [3];
   logic [1:0] volt_phase [3];
   logic cfg_hit;
   logic cfg_write;
   logic soft_reset_done;

   assign cfg_hit = (addr_i == CFG_ADDR);
   // Writes are ignored while a software reset is running
   assign cfg_write = wr_i && cfg_hit && (state == SR_IDLE);
   assign soft_reset_done = (state == SR_BUSY) && (reset_count == 32'(SOFT_RESET_CYCLES - 1));

   // Single-bit configuration fields
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || soft_reset_done) begin
         settle_sel <= CFG_BIT_RESET;
         fast_port_en <= CFG_BIT_RESET;
         neutral_sel <= CFG_BIT_RESET;
      end else if (cfg_write) begin
         settle_sel <= wdata_i[SETTLE_BIT];
         fast_port_en <= wdata_i[FAST_PORT_BIT];
         neutral_sel <= wdata_i[NEUTRAL_SRC_BIT];
      end
   end

   // Voltage pairing fields, one per phase current
   localparam int VOLT_LSB [3] = '{VOLT_A_LSB, VOLT_B_LSB, VOLT_C_LSB};
   localparam logic [1:0] VOLT_BASE [3] = '{PHASE_A, PHASE_B, PHASE_C};
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gen_phase
         always_ff @(posedge ref_clk_i) begin
            if (rst_i || soft_reset_done) begin
               volt_field[g] <= VOLT_FIELD_RESET;
            end else if (cfg_write) begin
               volt_field[g] <= wdata_i[VOLT_LSB[g] +: 2];
            end
         end
         phase_voltage_map #(
            .BASE_PHASE(VOLT_BASE[g])
         ) u_map (
            .field_i(volt_field[g]),
            .phase_o(volt_phase[g])
         );
      end
   endgenerate

   // Software reset sequencer
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state <= SR_IDLE;
         reset_count <= 32'h0000_0000;
      end else begin
         case (state)
            SR_IDLE: begin
               reset_count <= 32'h0000_0000;
               if (cfg_write && wdata_i[SOFT_RESET_BIT]) begin
                  state <= SR_BUSY;
               end
            end
            SR_BUSY: begin
               if (soft_reset_done) begin
                  state <= SR_IDLE;
                  reset_count <= 32'h0000_0000;
               end else begin
                  reset_count <= reset_count + 32'h0000_0001;
               end
            end
            default: begin
               state <= SR_IDLE;
               reset_count <= 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         soft_reset_o <= 1'h0;
      end else begin
         soft_reset_o <= cfg_write ? wdata_i[SOFT_RESET_BIT] : (state == SR_BUSY) && !soft_reset_done;
      end
   end

   // Read port: data only in the cycle after the strobe
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rdata_o <= READ_IDLE;
      end else if (rd_i && cfg_hit) begin
         rdata_o <= READ_IDLE;
         rdata_o[SETTLE_BIT] <= settle_sel;
         rdata_o[FAST_PORT_BIT] <= fast_port_en;
         rdata_o[SOFT_RESET_BIT] <= (state == SR_BUSY);
         rdata_o[VOLT_A_LSB +: 2] <= volt_field[0];
         rdata_o[VOLT_B_LSB +: 2] <= volt_field[1];
         rdata_o[VOLT_C_LSB +: 2] <= volt_field[2];
         rdata_o[NEUTRAL_SRC_BIT] <= neutral_sel; // bit 15 stays zero
      end else begin
         rdata_o <= READ_IDLE;
      end
   end

   // Registered effects of the fields
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         power_filter_settle_select_o <= CFG_BIT_RESET;
         filter_settle_cycles_o <= 32'(SETTLE_SHORT_CYCLES);
      end else begin
         power_filter_settle_select_o <= settle_sel;
         filter_settle_cycles_o <= settle_sel ? 32'(SETTLE_LONG_CYCLES)
                                              : 32'(SETTLE_SHORT_CYCLES);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         fast_data_port_enable_o <= CFG_BIT_RESET;
         shared_pin_o <= 1'h0;
      end else begin
         fast_data_port_enable_o <= fast_port_en;
         shared_pin_o <= fast_port_en ? fast_port_clock_i : third_pulse_output_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         voltage_for_current_a_o <= PHASE_A;
         voltage_for_current_b_o <= PHASE_B;
         voltage_for_current_c_o <= PHASE_C;
      end else begin
         voltage_for_current_a_o <= volt_phase[0];
         voltage_for_current_b_o <= volt_phase[1];
         voltage_for_current_c_o <= volt_phase[2];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         neutral_rms_source_select_o <= CFG_BIT_RESET;
         neutral_rms_o <= '0;
      end else begin
         neutral_rms_source_select_o <= neutral_sel;
         neutral_rms_o <= neutral_sel ? phase_current_sum_i : neutral_current_rms_i;
      end
   end

   // Checks
   sequence s_reset_start;
      cfg_write && wdata_i[SOFT_RESET_BIT];
   endsequence

   sequence s_reset_hold;
      soft_reset_o [*8];
   endsequence

   property p_settle_time;
      @(posedge ref_clk_i) disable iff (rst_i)
      cfg_write |-> ##2 (filter_settle_cycles_o == ($past(wdata_i[SETTLE_BIT], 2)
         ? 32'(SETTLE_LONG_CYCLES) : 32'(SETTLE_SHORT_CYCLES)));
   endproperty
   a_settle_time: assert property (p_settle_time) else $error("settle time mismatch");

   property p_fast_pin;
      @(posedge ref_clk_i) disable iff (rst_i)
      fast_data_port_enable_o |-> (shared_pin_o == $past(fast_port_clock_i));
   endproperty
   a_fast_pin: assert property (p_fast_pin) else $error("shared pin not port clock");

   property p_pulse_pin;
      @(posedge ref_clk_i) disable iff (rst_i)
      (!fast_data_port_enable_o && !$past(rst_i)) |-> (shared_pin_o == $past(third_pulse_output_i));
   endproperty
   a_pulse_pin: assert property (p_pulse_pin) else $error("shared pin not pulse output");

   property p_reset_start;
      @(posedge ref_clk_i) disable iff (rst_i)
      s_reset_start |=> s_reset_hold;
   endproperty
   a_reset_start: assert property (p_reset_start) else $error("soft reset did not start");

   property p_reset_ends;
      @(posedge ref_clk_i) disable iff (rst_i)
      $rose(soft_reset_o) |-> ##[1:1000] !soft_reset_o;
   endproperty
   a_reset_ends: assert property (p_reset_ends) else $error("soft reset never ended");

   property p_reset_clears;
      @(posedge ref_clk_i) disable iff (rst_i)
      $fell(soft_reset_o) |-> (state == SR_IDLE) ##1 (!power_filter_settle_select_o
         && !fast_data_port_enable_o && !neutral_rms_source_select_o
         && voltage_for_current_a_o == PHASE_A && voltage_for_current_b_o == PHASE_B
         && voltage_for_current_c_o == PHASE_C);
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("soft reset left fields");

   property p_volt_a;
      @(posedge ref_clk_i) disable iff (rst_i)
      (cfg_write && wdata_i[VOLT_A_LSB +: 2] == PHASE_RSVD) |-> ##2 (voltage_for_current_a_o == PHASE_A);
   endproperty
   a_volt_a: assert property (p_volt_a) else $error("reserved pairing A not own phase");

   property p_volt_b;
      @(posedge ref_clk_i) disable iff (rst_i)
      (cfg_write && wdata_i[VOLT_B_LSB +: 2] == 2'h2) |-> ##2 (voltage_for_current_b_o == PHASE_A);
   endproperty
   a_volt_b: assert property (p_volt_b) else $error("pairing B code 2 not phase A");

   property p_volt_c;
      @(posedge ref_clk_i) disable iff (rst_i)
      (cfg_write && wdata_i[VOLT_C_LSB +: 2] == 2'h1) |-> ##2 (voltage_for_current_c_o == PHASE_A);
   endproperty
   a_volt_c: assert property (p_volt_c) else $error("pairing C code 1 not phase A");

   property p_neutral;
      @(posedge ref_clk_i) disable iff (rst_i)
      neutral_rms_source_select_o |-> (neutral_rms_o == $past(phase_current_sum_i));
   endproperty
   a_neutral: assert property (p_neutral) else $error("neutral rms source wrong");

   property p_reserved;
      @(posedge ref_clk_i) disable iff (rst_i)
      $past(rd_i) |-> (rdata_o[15] == 1'b0);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit reads one");

   property p_unmapped;
      @(posedge ref_clk_i) disable iff (rst_i)
      (rd_i && !cfg_hit) |=> (rdata_o == READ_IDLE);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking testbench for the upper configuration register fields
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import metering_cfg_pkg::*;
;
   localparam int unsigned SHORT_CYC = 65;
   localparam int unsigned LONG_CYC = 130;
   localparam int unsigned SR_CYC = 8;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic pulse3 = 1'b0;
   logic fast_clk = 1'b1;
   logic [23:0] nrms = 24'h00_0000;
   logic [23:0] psum = 24'hFF_FFFF;
   logic [15:0] rdata;
   logic settle_sel, port_en, pin, soft_reset, neutral_sel;
   logic [31:0] settle_cyc;
   logic [1:0] volt_a, volt_b, volt_c;
   logic [23:0] neutral_rms;
   int bad_count = 0;
   int n_compared = 0;

   metering_config_upper_fields #(.SETTLE_SHORT_CYCLES(SHORT_CYC), .SETTLE_LONG_CYCLES(LONG_CYC),
      .SOFT_RESET_CYCLES(SR_CYC), .RMS_WIDTH(24)) uut (
      .ref_clk_i(ref_clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .power_filter_settle_select_o(settle_sel),
      .filter_settle_cycles_o(settle_cyc), .fast_data_port_enable_o(port_en),
      .third_pulse_output_i(pulse3), .fast_port_clock_i(fast_clk), .shared_pin_o(pin),
      .soft_reset_o(soft_reset), .voltage_for_current_a_o(volt_a),
      .voltage_for_current_b_o(volt_b), .voltage_for_current_c_o(volt_c),
      .neutral_rms_source_select_o(neutral_sel), .neutral_current_rms_i(nrms),
      .phase_current_sum_i(psum), .neutral_rms_o(neutral_rms));

   always #12.5 ref_clk = ~ref_clk;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("Compared %0d values, %0d mismatches", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Phase code paired with a current, reserved code acts as zero
   function automatic logic [1:0] vmap(input logic [1:0] f, input logic [1:0] base);
      logic [1:0] step;
      step = (f == 2'h3) ? 2'h0 : f;
      return 2'((int'(base) + int'(step)) % 3);
   endfunction

   task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic settle();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   task automatic check_outs(input logic [15:0] d);
      check("settle_sel", settle_sel, d[5]);
      check("settle_cyc", settle_cyc, d[5] ? LONG_CYC : SHORT_CYC);
      check("port_en", port_en, d[6]);
      check("shared_pin", pin, d[6] ? fast_clk : pulse3);
      check("volt_a", volt_a, vmap(d[9:8], PHASE_A));
      check("volt_b", volt_b, vmap(d[11:10], PHASE_B));
      check("volt_c", volt_c, vmap(d[13:12], PHASE_C));
      check("neutral_sel", neutral_sel, d[14]);
      check("neutral_rms", neutral_rms, d[14] ? psum : nrms);
   endtask

   initial begin
      repeat (5000) @(posedge ref_clk);
      bad_count++;
      complete_run();
   end

   initial begin
      logic [15:0] d, v;
      logic b;
      int n;
      void'($urandom(32'h55e4));
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      settle();
      check_outs(16'h0000);
      check("soft_reset_idle", soft_reset, 1'b0);
      bus_rd(CFG_ADDR, v);
      check("rd_reset", v, 16'h0000);
      for (int i = 0; i < 28; i++) begin
         d = (i < 4) ? {2'b11, {3{2'(i)}}, 8'h7F} : 16'($urandom);
         d = d & 16'hFF7F;
         b = 1'($urandom);
         @(posedge ref_clk);
         pulse3 <= b;
         fast_clk <= ~b;
         nrms <= 24'($urandom);
         psum <= 24'($urandom);
         bus_wr(CFG_ADDR, d);
         settle();
         check_outs(d);
         bus_rd(CFG_ADDR, v);
         check("rd_back", v, d & 16'h7F60);
         @(posedge ref_clk);
         #1;
         check("rd_idle", rdata, 16'h0000);
      end
      bus_wr(CFG_ADDR + 16'h0001, ~d);
      settle();
      check_outs(d);
      check("soft_reset_unmapped", soft_reset, 1'b0);
      bus_rd(CFG_ADDR + 16'h0001, v);
      check("rd_unmapped", v, 16'h0000);
      @(posedge ref_clk);
      rst <= 1'b1;
      @(posedge ref_clk);
      rst <= 1'b0;
      settle();
      check_outs(16'h0000);
      bus_wr(CFG_ADDR, 16'h0080);
      #1;
      check("soft_reset", soft_reset, 1'b1);
      n = 0;
      while (soft_reset === 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check("reset_len", n, SR_CYC);
      d = 16'h7AE0;
      bus_wr(CFG_ADDR, d);
      bus_rd(CFG_ADDR, v);
      check("rd_busy", v, d & 16'h7FE0);
      bus_wr(CFG_ADDR, 16'h0000);
      settle();
      check_outs(d & 16'hFF7F);
      n = 0;
      while (soft_reset === 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check("soft_reset_end", soft_reset, 1'b0);
      settle();
      check_outs(16'h0000);
      bus_rd(CFG_ADDR, v);
      check("rd_after_reset", v, 16'h0000);
      complete_run();
   end
endmodule
`default_nettype wire
